// ===== rtl/rtc_map.svh
// Register offsets, field positions, reset values and timing counts of the watch block
// Assumes a 125 MHz system clock; the 32.768 kHz crystal is a sampled input pin
// Notes on behaviour
// - Prescaler turns crystal into one hertz tick
// - Seconds, minutes, hours, day counters cascaded
// - Selectable second, minute, day periodic interrupts
// - Enabled alarm interrupts when counters match
// - Time-of-day alarm and day-plus-time alarm
// - Stopwatch loads value, decrements every minute
// - Enabled stopwatch interrupts on underflow past zero
// - Any interrupt doubles as wake request
// - Deep-sleep wake forces full-on, bypass ignored
// - Keeps counting in sleep, no memory access
// - Runs independent of core clock gating
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define RTC_OFF_TIME     12'h000
`define RTC_OFF_CTRL     12'h004
`define RTC_OFF_ALARM0   12'h008
`define RTC_OFF_ALARM1   12'h00C
`define RTC_OFF_SWLOAD   12'h010
`define RTC_OFF_SWCOUNT  12'h014
`define RTC_OFF_STATUS   12'h018
`define RTC_OFF_MASK     12'h01C

// ************************************************************
// Field positions
// ************************************************************
`define RTC_SEC_LSB      0
`define RTC_MIN_LSB      8
`define RTC_HOUR_LSB     16
`define RTC_DAY_LSB      24
`define RTC_CTL_ALM0EN   0
`define RTC_CTL_ALM1EN   1
`define RTC_CTL_SWEN     2
`define RTC_CTL_SECIE    3
`define RTC_CTL_MINIE    4
`define RTC_CTL_DAYIE    5
`define RTC_ST_SEC       0
`define RTC_ST_MIN       1
`define RTC_ST_DAY       2
`define RTC_ST_ALM0      3
`define RTC_ST_ALM1      4
`define RTC_ST_SW        5
`define RTC_NUM_EVT      6

// ************************************************************
// Reset values and counts
// ************************************************************
`define RTC_CTRL_RST     6'h00
`define RTC_MASK_RST     6'h00
`define RTC_XTAL_HZ      32768
`define RTC_SEC_MAX      6'd59
`define RTC_MIN_MAX      6'd59
`define RTC_HOUR_MAX     5'd23
`define RTC_RESP_OKAY    2'b00
`define RTC_RESP_SLVERR  2'b10

`endif

// ===== rtl/rtc_pkg.sv
// Types shared by the watch block
// Assumes rtc_map.svh is on the include path
package rtc_pkg;

  // ************************************************************
  // Time of day and day count
  // ************************************************************
  typedef struct packed {
    logic [7:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtc_time_t;

  // Power manager wake request
  typedef struct packed {
    logic wake;
    logic fullOn;
  } rtc_wake_t;

endpackage : rtc_pkg

// ===== rtl/rtc_watch.sv
// Watch block: crystal prescaler, time counters, alarms, stopwatch and AXI4-Lite slave
// Assumes the crystal pin is synchronous to clk and this clock stays on in deep sleep
`include "rtc_map.svh"

module rtc_watch (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               xtalIn,
  input  wire logic               deepSleep,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    irq,
  output rtc_pkg::rtc_wake_t      wakeReq
);
  import rtc_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Byte-lane merge of a write into a 32-bit word
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // Packs a time value into its register layout
  function automatic logic [31:0] packTime(input rtc_time_t t);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`RTC_SEC_LSB +: 6] = t.second;
    r[`RTC_MIN_LSB +: 6] = t.minute;
    r[`RTC_HOUR_LSB +: 5] = t.hour;
    r[`RTC_DAY_LSB +: 8] = t.day;
    return r;
  endfunction : packTime

  // Unpacks a register word into a time value
  function automatic rtc_time_t unpackTime(input logic [31:0] w);
    rtc_time_t t;
    t.second = w[`RTC_SEC_LSB +: 6];
    t.minute = w[`RTC_MIN_LSB +: 6];
    t.hour   = w[`RTC_HOUR_LSB +: 5];
    t.day    = w[`RTC_DAY_LSB +: 8];
    return t;
  endfunction : unpackTime

  // Compares hour, minute and second, and the day too when asked
  function automatic logic timeMatch(input rtc_time_t t, input rtc_time_t a,
                                     input logic withDay);
    return (t.second == a.second) && (t.minute == a.minute) && (t.hour == a.hour) &&
           (!withDay || (t.day == a.day));
  endfunction : timeMatch

  // ************************************************************
  // Prescaler
  // ************************************************************
  logic        xtalPrev;
  logic [14:0] prescale;
  logic        xtalRise;
  logic        secTick;

  // One crystal period per rise; a full 15-bit wrap is one second
  assign xtalRise = xtalIn & ~xtalPrev;
  assign secTick  = xtalRise && (prescale == 15'(`RTC_XTAL_HZ - 1));

  // Prescaler counts crystal edges, not gated by sleep
  // A crystal stuck at one level gives no rises, so time simply holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtalPrev <= 1'b0;
      prescale <= 15'h0000;
    end else begin
      xtalPrev <= xtalIn;
      if (xtalRise) begin
        prescale <= prescale + 15'h0001;
      end
    end
  end

  // ************************************************************
  // Time counters
  // ************************************************************
  rtc_time_t   now;
  rtc_time_t   next_now;
  logic        minTick;
  logic        hourTick;
  logic        dayTick;
  logic        liveTick;
  logic        timeWr;
  logic [31:0] timeWdata;
  logic [3:0]  timeWstrb;

  // A software time write in the tick cycle swallows that tick, so no
  // stale carry or alarm is raised against the value being replaced
  assign liveTick = secTick && !timeWr;

  // Carries ripple on the seconds tick
  assign minTick  = liveTick && (now.second == `RTC_SEC_MAX);
  assign hourTick = minTick && (now.minute == `RTC_MIN_MAX);
  assign dayTick  = hourTick && (now.hour == `RTC_HOUR_MAX);

  // Next time value; a software write replaces its strobed byte lanes at once
  always_comb begin
    next_now = now;
    if (timeWr) begin
      next_now = unpackTime(mergeBytes(packTime(now), timeWdata, timeWstrb));
    end else if (liveTick) begin
      next_now.second = minTick ? 6'h00 : now.second + 6'h01;
      if (minTick) begin
        next_now.minute = hourTick ? 6'h00 : now.minute + 6'h01;
      end
      if (hourTick) begin
        next_now.hour = dayTick ? 5'h00 : now.hour + 5'h01;
      end
      if (dayTick) begin
        next_now.day = now.day + 8'h01;
      end
    end
  end

  // Time register keeps running through deep sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      now <= '0;
    end else begin
      now <= next_now;
    end
  end

  // ************************************************************
  // Control, alarms and stopwatch
  // ************************************************************
  logic [5:0]  ctrl;
  logic [31:0] alarm0;
  logic [31:0] alarm1;
  logic [7:0]  swLoad;
  logic [7:0]  swCount;
  logic        swWr;
  logic        ctrlWr;
  logic        alm0Wr;
  logic        alm1Wr;
  logic        alm0Hit;
  logic        alm1Hit;
  logic        swUnder;
  logic        swStep;
  rtc_time_t   a0;
  rtc_time_t   a1;

  assign a0 = unpackTime(alarm0);
  assign a1 = unpackTime(alarm1);

  // Alarms fire once, on the live tick that lands on the programmed time;
  // alarm 0 ignores the day field, alarm 1 needs the day as well
  assign alm0Hit = liveTick && ctrl[`RTC_CTL_ALM0EN] &&
                   timeMatch(next_now, a0, 1'b0);
  assign alm1Hit = liveTick && ctrl[`RTC_CTL_ALM1EN] &&
                   timeMatch(next_now, a1, 1'b1);
  // Stopwatch moves on each minute rollover while enabled
  assign swStep  = minTick && ctrl[`RTC_CTL_SWEN];
  // Underflow is the minute step taken while already at zero
  assign swUnder = swStep && (swCount == 8'h00);

  // Software settings and stopwatch countdown
  // Every register in this block takes the captured write word, never the live bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= `RTC_CTRL_RST;
      alarm0  <= 32'h0000_0000;
      alarm1  <= 32'h0000_0000;
      swLoad  <= 8'h00;
      swCount <= 8'h00;
    end else begin
      if (ctrlWr) begin
        ctrl <= 6'(mergeBytes({26'h0, ctrl}, timeWdata, timeWstrb));
      end
      if (alm0Wr) begin
        alarm0 <= mergeBytes(alarm0, timeWdata, timeWstrb);
      end
      if (alm1Wr) begin
        alarm1 <= mergeBytes(alarm1, timeWdata, timeWstrb);
      end
      if (swWr) begin
        swLoad  <= 8'(mergeBytes({24'h0, swLoad}, timeWdata, timeWstrb));
        swCount <= 8'(mergeBytes({24'h0, swLoad}, timeWdata, timeWstrb));
      end else if (swStep) begin
        swCount <= swCount - 8'h01;
      end
    end
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  logic [5:0] status;
  logic [5:0] mask;
  logic [5:0] events;
  logic       stWr;
  logic       maskWr;
  logic [5:0] stClear;

  assign events = {swUnder, alm1Hit, alm0Hit,
                   dayTick && ctrl[`RTC_CTL_DAYIE],
                   minTick && ctrl[`RTC_CTL_MINIE],
                   liveTick && ctrl[`RTC_CTL_SECIE]};
  assign stClear = stWr && timeWstrb[0] ? timeWdata[5:0] : 6'h00;

  // Sticky flags; a new event beats a same-cycle clear
  // Interrupt and wake follow status one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status  <= 6'h00;
      mask    <= `RTC_MASK_RST;
      irq     <= 1'b0;
      wakeReq <= '0;
    end else begin
      status <= (status & ~stClear) | events;
      if (maskWr) begin
        mask <= 6'(mergeBytes({26'h0, mask}, s_axi_wdata, s_axi_wstrb));
      end
      irq            <= |(status & mask);
      wakeReq.wake   <= |(status & mask);
      wakeReq.fullOn <= |(status & mask) & deepSleep;
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wrGo;
  logic        wrHit;

  assign wrGo      = awHeld && wHeld && !s_axi_bvalid;
  assign timeWdata = wData;
  assign timeWstrb = wStrb;
  assign timeWr = wrGo && (awAddr == `RTC_OFF_TIME);
  assign ctrlWr = wrGo && (awAddr == `RTC_OFF_CTRL);
  assign alm0Wr = wrGo && (awAddr == `RTC_OFF_ALARM0);
  assign alm1Wr = wrGo && (awAddr == `RTC_OFF_ALARM1);
  assign swWr   = wrGo && (awAddr == `RTC_OFF_SWLOAD);
  assign stWr   = wrGo && (awAddr == `RTC_OFF_STATUS);
  assign maskWr = wrGo && (awAddr == `RTC_OFF_MASK);
  assign wrHit  = timeWr | ctrlWr | alm0Wr | alm1Wr | swWr | stWr | maskWr |
                  (wrGo && (awAddr == `RTC_OFF_SWCOUNT));

  // Address and data captured independently, response once both are in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 12'h000;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RTC_RESP_OKAY;
    end else begin
      // Neither channel is taken while a response waits to be collected
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic [31:0] rdMux;
  logic        rdHit;
  logic [11:0] rdAddr;

  assign rdAddr = {s_axi_araddr[11:2], 2'b00};
  assign rdHit  = (rdAddr <= `RTC_OFF_MASK);
  // Whole time word taken in one cycle, so no torn read
  assign rdMux = (rdAddr == `RTC_OFF_TIME)    ? packTime(now) :
                 (rdAddr == `RTC_OFF_CTRL)    ? {26'h0, ctrl} :
                 (rdAddr == `RTC_OFF_ALARM0)  ? alarm0 :
                 (rdAddr == `RTC_OFF_ALARM1)  ? alarm1 :
                 (rdAddr == `RTC_OFF_SWLOAD)  ? {24'h0, swLoad} :
                 (rdAddr == `RTC_OFF_SWCOUNT) ? {24'h0, swCount} :
                 (rdAddr == `RTC_OFF_STATUS)  ? {26'h0, status} :
                 (rdAddr == `RTC_OFF_MASK)    ? {26'h0, mask} : 32'h0000_0000;

  // One read in flight; data registered with the address handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RTC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : rtc_watch

// ===== tb/rtc_watch_chk.sv
// Port-level assertions for the watch block
// Assumes one clock domain and the ports of rtc_watch
module rtc_watch_chk (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               deepSleep,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               irq,
  input wire rtc_pkg::rtc_wake_t wakeReq
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Wake path follows the interrupt line
  a_wake_irq: assert property (wakeReq.wake == irq)
    else $error("wake request differs from interrupt");
  a_fullon_sleep: assert property (wakeReq.fullOn |-> irq && $past(deepSleep))
    else $error("full-on request outside deep sleep");
  a_fullon_irq: assert property (irq && $past(deepSleep) |-> wakeReq.fullOn)
    else $error("no full-on request for interrupt in deep sleep");
  // Bus answers stay put until taken
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
  a_b_after: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after capture");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returned data");
endmodule : rtc_watch_chk

bind rtc_watch rtc_watch_chk rtc_watch_chk_inst (
  .clk(clk), .rst_n(rst_n), .deepSleep(deepSleep), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq), .wakeReq(wakeReq));

// ===== tb/rtc_power_mgr.sv
// Power manager model: enters deep sleep on request, leaves it on a full-on request
// Assumes the system clock of the watch block
module rtc_power_mgr (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               sleepReq,
  input  wire rtc_pkg::rtc_wake_t wakeReq,
  output logic                    deepSleep
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  // Wake wins over sleep; no bypass level is consulted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) deepSleep <= 1'b0;
    else if (wakeReq.fullOn) deepSleep <= 1'b0;
    else if (sleepReq) deepSleep <= 1'b1;
  end
endmodule : rtc_power_mgr

// ===== tb/rtc_watch_alarm_stopwatch_tb_top.sv
// Testbench: register tasks, crystal drive, one full wrap tick in deep sleep
// Assumes rtc_map.svh on the include path and the checker bound by its own file
`include "rtc_map.svh"
module rtc_watch_alarm_stopwatch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic        clk, rst_n, xtalIn, sleepReq, deepSleep, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        sawFullOn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  wstrb;
  rtc_wake_t   wakeReq;
  int          badCount = 0;
  int          checksDone = 0;

  rtc_watch rtc_watch_inst (
    .clk(clk), .rst_n(rst_n), .xtalIn(xtalIn), .deepSleep(deepSleep),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .wakeReq(wakeReq));
  rtc_power_mgr rtc_power_mgr_inst (.clk(clk), .rst_n(rst_n), .sleepReq(sleepReq),
    .wakeReq(wakeReq), .deepSleep(deepSleep));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Remember any full-on request
  always @(posedge clk) if (wakeReq.fullOn === 1'b1) sawFullOn <= 1'b1;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Write: address, data and bready together; each released at its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  // Read: rready offered with the address, data taken at the rvalid edge
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    check(nm, d, e);
    check(nm, {30'h0, r}, 32'h0000_0000);
  endtask : rdc

  // One crystal period is one rise seen on clk
  task automatic xtal(input int n);
    repeat (n) begin
      @(posedge clk);
      xtalIn <= 1'b1;
      @(posedge clk);
      xtalIn <= 1'b0;
    end
  endtask : xtal

  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : endSim

  // Watchdog
  initial begin
    #(90000 * 8);
    badCount++;
    endSim();
  end

  // Main sequence: one tick wraps seconds, minutes and hours, steps the day and fires every event
  initial begin
    rst_n = 1'b0;
    xtalIn = 1'b0;
    sleepReq = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc("time rst", `RTC_OFF_TIME, 32'h0000_0000);
    rdc("ctrl rst", `RTC_OFF_CTRL, 32'h0000_0000);
    rdc("mask rst", `RTC_OFF_MASK, 32'h0000_0000);
    rd(12'h020);
    check("rd err", {30'h0, r}, 32'h0000_0002);
    check("rd err data", d, 32'h0000_0000);
    wr(12'h024, 32'hFFFF_FFFF);
    check("wr err", {30'h0, r}, 32'h0000_0002);
    wr(`RTC_OFF_TIME, 32'h0517_3B3B);
    check("wr ok", {30'h0, r}, 32'h0000_0000);
    rdc("time set", `RTC_OFF_TIME, 32'h0517_3B3B);
    wr(`RTC_OFF_ALARM0, 32'h7700_0000);
    wstrb <= 4'h8;
    wr(`RTC_OFF_ALARM1, 32'h06FF_FFFF);
    wstrb <= 4'hF;
    rdc("alarm1 lane", `RTC_OFF_ALARM1, 32'h0600_0000);
    wr(`RTC_OFF_SWLOAD, 32'h0000_0000);
    wr(`RTC_OFF_CTRL, 32'h0000_003F);
    rdc("ctrl", `RTC_OFF_CTRL, 32'h0000_003F);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    xtal(32767);
    rdc("time pre", `RTC_OFF_TIME, 32'h0517_3B3B);
    xtal(1);
    repeat (8) @(posedge clk);
    rdc("time wrap", `RTC_OFF_TIME, 32'h0600_0000);
    rdc("status", `RTC_OFF_STATUS, 32'h0000_003F);
    rdc("sw count", `RTC_OFF_SWCOUNT, 32'h0000_00FF);
    check("masked irq", {31'h0, irq}, 32'h0000_0000);
    check("sleeping", {31'h0, deepSleep}, 32'h0000_0001);
    wr(`RTC_OFF_MASK, 32'h0000_003F);
    repeat (4) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    check("wake", {31'h0, wakeReq.wake}, 32'h0000_0001);
    check("full on", {31'h0, sawFullOn}, 32'h0000_0001);
    check("awake", {31'h0, deepSleep}, 32'h0000_0000);
    wr(`RTC_OFF_STATUS, 32'h0000_003F);
    rdc("status clr", `RTC_OFF_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check("irq clr", {31'h0, irq}, 32'h0000_0000);
    endSim();
  end
endmodule : rtc_watch_alarm_stopwatch_tb_top
